// File: src/nvm_pkg.sv
// constants and types shared by the serial nonvolatile memory access block
package nvm_pkg;
  localparam int ARRAY_BYTES = 256;
  localparam int PAGE_BYTES = 8;
  localparam int PROT_BYTES = 16;
  localparam logic [7:0] PROT_LAST = 8'h0F;
  localparam logic [7:0] UNLOCK_KEY1 = 8'h55;
  localparam logic [7:0] UNLOCK_KEY2 = 8'hAA;
  localparam int WIP_BIT = 0;
  localparam int WEL_BIT = 1;
  localparam int SEL_LSB = 2;
  localparam logic [1:0] PROTECT_RESET = 2'h0;
  localparam int CLK_MHZ = 100;
  localparam int WRITE_TIME_US = 5000;
  localparam int WRITE_CYCLES = WRITE_TIME_US * CLK_MHZ;
  // opcode defaults are arbitrary, override per part
  localparam logic [7:0] OP_SR_READ = 8'h05;
  localparam logic [7:0] OP_SR_WRITE = 8'h01;
  localparam logic [7:0] OP_WR_EN = 8'h06;
  localparam logic [7:0] OP_WR_DIS = 8'h04;
  localparam logic [7:0] OP_ARR_READ = 8'h03;
  localparam logic [7:0] OP_ARR_WRITE = 8'h02;
  localparam logic [7:0] OP_PROT_READ = 8'h33;
  localparam logic [7:0] OP_PROT_WRITE = 8'h32;
  localparam logic [7:0] OP_UNLOCK = 8'h14;
  typedef enum logic [2:0] {
    ST_OPCODE = 3'h0,
    ST_ADDR = 3'h1,
    ST_DATA = 3'h2,
    ST_READ = 3'h3,
    ST_IGNORE = 3'h4
  } frame_state_e;
  typedef enum logic [3:0] {
    CMD_NONE = 4'h0,
    CMD_SR_READ = 4'h1,
    CMD_SR_WRITE = 4'h2,
    CMD_WR_EN = 4'h3,
    CMD_WR_DIS = 4'h4,
    CMD_ARR_READ = 4'h5,
    CMD_ARR_WRITE = 4'h6,
    CMD_PROT_READ = 4'h7,
    CMD_PROT_WRITE = 4'h8,
    CMD_UNLOCK = 4'h9
  } cmd_e;
endpackage

// File: src/nvm_links_if.sv
// carriers between the sequencer, the serial engine and the memory
`timescale 1ns/1ps
interface spi_link_if;
  logic byteValid;
  logic [7:0] rxByte;
  logic frameEnd;
  logic aligned;
  logic txLoad;
  logic [7:0] txByte;
  modport engine(output byteValid, rxByte, frameEnd, aligned, input txLoad, txByte);
  modport seq(input byteValid, rxByte, frameEnd, aligned, output txLoad, txByte);
endinterface

interface nvm_mem_if;
  logic rdSel;
  logic [7:0] rdAddr;
  logic [7:0] rdData;
  logic bufWr;
  logic bufClr;
  logic [2:0] bufIdx;
  logic [7:0] bufData;
  logic commit;
  logic commitSel;
  logic [7:0] commitPage;
  modport mem(input rdSel, rdAddr, bufWr, bufClr, bufIdx, bufData, commit, commitSel,
    commitPage, output rdData);
  modport seq(output rdSel, rdAddr, bufWr, bufClr, bufIdx, bufData, commit, commitSel,
    commitPage, input rdData);
endinterface

// File: src/spi_bit_engine.sv
// serial slave bit engine: pin synchronisers, byte assembly, reply shifter
`timescale 1ns/1ps
module spi_bit_engine (
  input wire logic clk,
  input wire logic rst,
  input wire logic csN,
  input wire logic sck,
  input wire logic si,
  output logic so,
  spi_link_if.engine lnk
);
  logic [1:0] csSync_q;
  logic [1:0] sckSync_q;
  logic [1:0] siSync_q;
  logic csPrev_q;
  logic sckPrev_q;
  logic [2:0] bitCnt_q, bitCnt_d;
  logic [6:0] rx_q, rx_d;
  logic [7:0] tx_q, tx_d;
  logic csHigh;
  logic sckRise;
  logic sckFall;

  // pins come from the host clock domain, two stages before use
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      csSync_q <= 2'h3;
      sckSync_q <= 2'h0;
      siSync_q <= 2'h0;
      csPrev_q <= 1'b1;
      sckPrev_q <= 1'b0;
    end else begin
      csSync_q <= {csSync_q[0], csN};
      sckSync_q <= {sckSync_q[0], sck};
      siSync_q <= {siSync_q[0], si};
      csPrev_q <= csSync_q[1];
      sckPrev_q <= sckSync_q[1];
    end
  end

  assign csHigh = csSync_q[1];
  assign sckRise = sckSync_q[1] & ~sckPrev_q & ~csHigh;
  assign sckFall = ~sckSync_q[1] & sckPrev_q & ~csHigh;
  assign lnk.frameEnd = csHigh & ~csPrev_q;
  assign lnk.aligned = (bitCnt_q == 3'h0);
  assign lnk.byteValid = sckRise & (bitCnt_q == 3'h7);
  assign lnk.rxByte = {rx_q, siSync_q[1]};
  assign so = tx_q[7];

  always_comb begin
    bitCnt_d = bitCnt_q;
    rx_d = rx_q;
    tx_d = tx_q;
    if (csHigh) begin
      bitCnt_d = 3'h0;
      // reply line idles low, so no stale bit shows between frames
      tx_d = 8'h00;
    end else begin
      if (sckRise) begin
        rx_d = {rx_q[5:0], siSync_q[1]};
        bitCnt_d = bitCnt_q + 3'h1;
      end
      // no shift on the first falling edge so a fresh byte shows its msb
      if (sckFall && bitCnt_q != 3'h0) begin
        tx_d = {tx_q[6:0], 1'b0};
      end
    end
    if (lnk.txLoad) begin
      tx_d = lnk.txByte;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      bitCnt_q <= 3'h0;
      rx_q <= 7'h00;
      tx_q <= 8'h00;
    end else begin
      bitCnt_q <= bitCnt_d;
      rx_q <= rx_d;
      tx_q <= tx_d;
    end
  end
endmodule // spi_bit_engine

// File: src/nvm_store.sv
// main array, protected array and the page buffer that feeds them
`timescale 1ns/1ps
module nvm_store #(
  parameter int ARRAY_BYTES = nvm_pkg::ARRAY_BYTES
) (
  input wire logic clk,
  input wire logic rst,
  nvm_mem_if.mem m
);
  localparam int AW = $clog2(ARRAY_BYTES);
  logic [7:0] mainMem [ARRAY_BYTES];
  logic [7:0] protMem [nvm_pkg::PROT_BYTES];
  logic [7:0] pageBuf [nvm_pkg::PAGE_BYTES];
  logic [nvm_pkg::PAGE_BYTES-1:0] mask_q, mask_d;

  assign m.rdData = m.rdSel ? protMem[m.rdAddr[3:0]] : mainMem[m.rdAddr[AW-1:0]];

  always_comb begin
    mask_d = mask_q;
    if (m.bufClr || m.commit) begin
      mask_d = '0;
    end
    if (m.bufWr) begin
      mask_d[m.bufIdx] = 1'b1;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      mask_q <= '0;
    end else begin
      mask_q <= mask_d;
    end
  end

  always_ff @(posedge clk) begin
    if (m.bufWr) begin
      pageBuf[m.bufIdx] <= m.bufData;
    end
  end

  for (genvar i = 0; i < nvm_pkg::PAGE_BYTES; i++) begin : g_slot
    // contents are nonvolatile, so no reset on the arrays
    always_ff @(posedge clk) begin
      if (m.commit && mask_q[i]) begin
        if (m.commitSel) begin
          protMem[{m.commitPage[3], 3'(i)}] <= pageBuf[i];
        end else begin
          mainMem[{m.commitPage[AW-1:3], 3'(i)}] <= pageBuf[i];
        end
      end
    end
  end
endmodule // nvm_store

// File: src/spi_nvm_status_access.sv
// serial slave sequencer for status register, array and protected region
`timescale 1ns/1ps
module spi_nvm_status_access #(
  parameter int ARRAY_BYTES = nvm_pkg::ARRAY_BYTES,
  parameter int WRITE_CYCLES = nvm_pkg::WRITE_CYCLES,
  parameter logic [7:0] OP_SR_READ = nvm_pkg::OP_SR_READ,
  parameter logic [7:0] OP_SR_WRITE = nvm_pkg::OP_SR_WRITE,
  parameter logic [7:0] OP_WR_EN = nvm_pkg::OP_WR_EN,
  parameter logic [7:0] OP_WR_DIS = nvm_pkg::OP_WR_DIS,
  parameter logic [7:0] OP_ARR_READ = nvm_pkg::OP_ARR_READ,
  parameter logic [7:0] OP_ARR_WRITE = nvm_pkg::OP_ARR_WRITE,
  parameter logic [7:0] OP_PROT_READ = nvm_pkg::OP_PROT_READ,
  parameter logic [7:0] OP_PROT_WRITE = nvm_pkg::OP_PROT_WRITE,
  parameter logic [7:0] OP_UNLOCK = nvm_pkg::OP_UNLOCK
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic csN,
  input wire logic sck,
  input wire logic si,
  output logic so,
  output logic soOe,
  output logic writeInProgress,
  output logic writeEnableLatch,
  output logic [1:0] protectSelect
);
  localparam int TW = $clog2(WRITE_CYCLES + 1);
  localparam logic [7:0] ARR_MASK = 8'(ARRAY_BYTES - 1);
  localparam logic [7:0] QUARTER3 = 8'(ARRAY_BYTES * 3 / 4);
  localparam logic [7:0] HALF = 8'(ARRAY_BYTES / 2);

  spi_link_if lnk ();
  nvm_mem_if mem ();

  spi_bit_engine u_engine (
    .clk(clk),
    .rst(rst),
    .csN(csN),
    .sck(sck),
    .si(si),
    .so(so),
    .lnk(lnk)
  );

  nvm_store #(.ARRAY_BYTES(ARRAY_BYTES)) u_store (
    .clk(clk),
    .rst(rst),
    .m(mem)
  );

  nvm_pkg::frame_state_e state_q, state_d;
  nvm_pkg::cmd_e cmd_q, cmd_d, cmdDec;
  logic [1:0] bytes_q, bytes_d;
  logic [7:0] ptr_q, ptr_d;
  logic [7:0] data_q, data_d;
  logic sel_q, sel_d;
  logic ignored_q, ignored_d;
  logic soOe_q, soOe_d;
  logic wel_q, wel_d;
  logic wip_q, wip_d;
  logic [1:0] protSel_q, protSel_d;
  logic [1:0] stage_q, stage_d;
  logic [TW-1:0] timer_q, timer_d;
  logic [7:0] status;
  logic isRead;
  logic startWrite;
  logic pageLocked;
  logic wholeFrame;

  assign soOe = soOe_q;
  assign writeInProgress = wip_q;
  assign writeEnableLatch = wel_q;
  assign protectSelect = protSel_q;

  always_comb begin
    cmdDec = nvm_pkg::CMD_NONE;
    if (lnk.rxByte == OP_SR_READ) cmdDec = nvm_pkg::CMD_SR_READ;
    if (lnk.rxByte == OP_SR_WRITE) cmdDec = nvm_pkg::CMD_SR_WRITE;
    if (lnk.rxByte == OP_WR_EN) cmdDec = nvm_pkg::CMD_WR_EN;
    if (lnk.rxByte == OP_WR_DIS) cmdDec = nvm_pkg::CMD_WR_DIS;
    if (lnk.rxByte == OP_ARR_READ) cmdDec = nvm_pkg::CMD_ARR_READ;
    if (lnk.rxByte == OP_ARR_WRITE) cmdDec = nvm_pkg::CMD_ARR_WRITE;
    if (lnk.rxByte == OP_PROT_READ) cmdDec = nvm_pkg::CMD_PROT_READ;
    if (lnk.rxByte == OP_PROT_WRITE) cmdDec = nvm_pkg::CMD_PROT_WRITE;
    if (lnk.rxByte == OP_UNLOCK) cmdDec = nvm_pkg::CMD_UNLOCK;
  end

  always_comb begin
    status = 8'h00;
    status[nvm_pkg::WIP_BIT] = wip_q;
    status[nvm_pkg::WEL_BIT] = wel_q;
    status[nvm_pkg::SEL_LSB +: 2] = protSel_q;
  end

  always_comb begin
    case (protSel_q)
      2'h0: pageLocked = 1'b0;
      2'h1: pageLocked = (ptr_q & ARR_MASK) >= QUARTER3;
      2'h2: pageLocked = (ptr_q & ARR_MASK) >= HALF;
      default: pageLocked = 1'b1;
    endcase
  end

  assign isRead = (cmd_q == nvm_pkg::CMD_ARR_READ) || (cmd_q == nvm_pkg::CMD_PROT_READ);
  assign wholeFrame = lnk.aligned && !ignored_q;
  assign mem.rdSel = sel_q;
  assign mem.rdAddr = (state_q == nvm_pkg::ST_ADDR) ? lnk.rxByte : ptr_q;
  assign mem.bufData = lnk.rxByte;
  assign mem.bufIdx = ptr_q[2:0];
  assign mem.commitSel = sel_q;
  assign mem.commitPage = ptr_q;

  function automatic logic [7:0] nextPtr(input logic [7:0] p, input logic prot);
    nextPtr = (p + 8'h01) & (prot ? nvm_pkg::PROT_LAST : ARR_MASK);
  endfunction

  always_comb begin
    state_d = state_q;
    cmd_d = cmd_q;
    bytes_d = bytes_q;
    ptr_d = ptr_q;
    data_d = data_q;
    sel_d = sel_q;
    ignored_d = ignored_q;
    soOe_d = soOe_q;
    wel_d = wel_q;
    wip_d = wip_q;
    protSel_d = protSel_q;
    stage_d = stage_q;
    timer_d = timer_q;
    startWrite = 1'b0;
    lnk.txLoad = 1'b0;
    lnk.txByte = mem.rdData;
    mem.bufWr = 1'b0;
    mem.bufClr = 1'b0;
    mem.commit = 1'b0;

    if (wip_q) begin
      if (timer_q == '0) begin
        wip_d = 1'b0;
        wel_d = 1'b0;
      end else begin
        timer_d = timer_q - TW'(1);
      end
    end

    if (lnk.byteValid) begin
      if (bytes_q != 2'h3) begin
        bytes_d = bytes_q + 2'h1;
      end
      case (state_q)
        nvm_pkg::ST_OPCODE: begin
          cmd_d = cmdDec;
          sel_d = (cmdDec == nvm_pkg::CMD_PROT_READ) || (cmdDec == nvm_pkg::CMD_PROT_WRITE);
          state_d = nvm_pkg::ST_IGNORE;
          if (cmdDec == nvm_pkg::CMD_SR_READ) begin
            lnk.txLoad = 1'b1;
            lnk.txByte = status;
            soOe_d = 1'b1;
            state_d = nvm_pkg::ST_READ;
          end else if (wip_q) begin
            ignored_d = 1'b1;
          end else if (cmdDec == nvm_pkg::CMD_SR_WRITE || cmdDec == nvm_pkg::CMD_UNLOCK) begin
            state_d = nvm_pkg::ST_DATA;
          end else if (cmdDec == nvm_pkg::CMD_ARR_READ || cmdDec == nvm_pkg::CMD_ARR_WRITE ||
              cmdDec == nvm_pkg::CMD_PROT_READ || cmdDec == nvm_pkg::CMD_PROT_WRITE) begin
            state_d = nvm_pkg::ST_ADDR;
          end
        end
        nvm_pkg::ST_ADDR: begin
          if (sel_q && lnk.rxByte > nvm_pkg::PROT_LAST) begin
            ignored_d = 1'b1;
            state_d = nvm_pkg::ST_IGNORE;
          end else if (isRead) begin
            lnk.txLoad = 1'b1;
            soOe_d = 1'b1;
            ptr_d = nextPtr(lnk.rxByte, sel_q);
            state_d = nvm_pkg::ST_READ;
          end else begin
            ptr_d = lnk.rxByte;
            mem.bufClr = 1'b1;
            state_d = nvm_pkg::ST_DATA;
          end
        end
        nvm_pkg::ST_DATA: begin
          if (cmd_q == nvm_pkg::CMD_ARR_WRITE || cmd_q == nvm_pkg::CMD_PROT_WRITE) begin
            mem.bufWr = 1'b1;
            ptr_d = {ptr_q[7:3], ptr_q[2:0] + 3'h1};
          end else begin
            data_d = lnk.rxByte;
          end
        end
        nvm_pkg::ST_READ: begin
          lnk.txLoad = 1'b1;
          if (cmd_q == nvm_pkg::CMD_SR_READ) begin
            lnk.txByte = status;
          end else begin
            ptr_d = nextPtr(ptr_q, sel_q);
          end
        end
        default: begin
          state_d = state_q;
        end
      endcase
    end

    if (lnk.frameEnd) begin
      state_d = nvm_pkg::ST_OPCODE;
      cmd_d = nvm_pkg::CMD_NONE;
      bytes_d = 2'h0;
      soOe_d = 1'b0;
      ignored_d = 1'b0;
      if (!ignored_q) begin
        case (cmd_q)
          nvm_pkg::CMD_WR_EN: begin
            if (wholeFrame && bytes_q == 2'h1) wel_d = 1'b1;
          end
          nvm_pkg::CMD_WR_DIS: begin
            if (wholeFrame && bytes_q == 2'h1) wel_d = 1'b0;
          end
          nvm_pkg::CMD_SR_WRITE: begin
            if (wholeFrame && bytes_q == 2'h2 && wel_q) begin
              protSel_d = data_q[nvm_pkg::SEL_LSB +: 2];
              startWrite = 1'b1;
            end
          end
          nvm_pkg::CMD_UNLOCK: begin
            if (wholeFrame && bytes_q == 2'h2 && wel_q && stage_q == 2'h0 &&
                data_q == nvm_pkg::UNLOCK_KEY1) begin
              stage_d = 2'h1;
            end else if (wholeFrame && bytes_q == 2'h2 && wel_q && stage_q == 2'h1 &&
                data_q == nvm_pkg::UNLOCK_KEY2) begin
              stage_d = 2'h2;
            end else begin
              stage_d = 2'h0;
              wel_d = 1'b0;
            end
          end
          nvm_pkg::CMD_ARR_WRITE: begin
            if (wholeFrame && bytes_q == 2'h3 && wel_q && !pageLocked) begin
              mem.commit = 1'b1;
              startWrite = 1'b1;
            end
          end
          nvm_pkg::CMD_PROT_WRITE: begin
            if (wholeFrame && bytes_q == 2'h3 && wel_q && stage_q == 2'h2) begin
              mem.commit = 1'b1;
              startWrite = 1'b1;
            end else begin
              wel_d = 1'b0;
            end
            stage_d = 2'h0;
          end
          default: begin
            stage_d = stage_q;
          end
        endcase
        if (stage_q != 2'h0 && cmd_q != nvm_pkg::CMD_SR_READ && cmd_q != nvm_pkg::CMD_NONE &&
            cmd_q != nvm_pkg::CMD_UNLOCK && cmd_q != nvm_pkg::CMD_PROT_WRITE) begin
          stage_d = 2'h0;
          wel_d = 1'b0;
        end
      end
    end

    // latch clears once the write completes
    if (startWrite) begin
      wip_d = 1'b1;
      timer_d = TW'(WRITE_CYCLES - 1);
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_q <= nvm_pkg::ST_OPCODE;
      cmd_q <= nvm_pkg::CMD_NONE;
      bytes_q <= 2'h0;
      ptr_q <= 8'h00;
      data_q <= 8'h00;
      sel_q <= 1'b0;
      ignored_q <= 1'b0;
      soOe_q <= 1'b0;
      wel_q <= 1'b0;
      wip_q <= 1'b0;
      protSel_q <= nvm_pkg::PROTECT_RESET;
      stage_q <= 2'h0;
      timer_q <= '0;
    end else begin
      state_q <= state_d;
      cmd_q <= cmd_d;
      bytes_q <= bytes_d;
      ptr_q <= ptr_d;
      data_q <= data_d;
      sel_q <= sel_d;
      ignored_q <= ignored_d;
      soOe_q <= soOe_d;
      wel_q <= wel_d;
      wip_q <= wip_d;
      protSel_q <= protSel_d;
      stage_q <= stage_d;
      timer_q <= timer_d;
    end
  end
endmodule // spi_nvm_status_access

// File: dv/spi_host_model.sv
// host master model for the serial link, mode 0, msb first
`timescale 1ns/1ps
module spi_host_model (
  input wire logic clk,
  input wire logic so,
  output logic csN,
  output logic sck,
  output logic si
);
  localparam int HALF_NS = 40;
  initial begin
    csN = 1'h1;
    sck = 1'h0;
    si = 1'h0;
  end
  task automatic select();
    @(posedge clk);
    #1 csN = 1'h0;
    #HALF_NS;
  endtask
  task automatic shift(input logic [7:0] tx, input int nBits, output logic [7:0] rx);
    rx = 8'h00;
    for (int i = 7; i > 7 - nBits; i--) begin
      si = tx[i];
      // reply is sampled just before the rise, when it has settled longest
      #HALF_NS;
      rx[i] = so;
      sck = 1'h1;
      #HALF_NS;
      sck = 1'h0;
    end
  endtask
  // deselect after the last bit sent
  task automatic deselect();
    #HALF_NS;
    csN = 1'h1;
    // unselected data line toggles, so a stale bit is never mistaken for data
    si = ~si;
    #(2 * HALF_NS);
  endtask
endmodule // spi_host_model

// File: dv/spi_nvm_status_access_sva.sv
// port-level checks of the serial nonvolatile access block
`timescale 1ns/1ps
module spi_nvm_status_access_sva #(
  parameter int WRITE_CYCLES = 20
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic csN,
  input wire logic so,
  input wire logic soOe,
  input wire logic writeInProgress,
  input wire logic writeEnableLatch,
  input wire logic [1:0] protectSelect
);
  // wide enough for the full default write time, not only the short bench one
  logic [31:0] busyCnt_q;
  logic [31:0] busyCnt_d;
  always_comb begin
    busyCnt_d = writeInProgress ? busyCnt_q + 32'h00000001 : 32'h00000000;
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      busyCnt_q <= 32'h00000000;
    end else begin
      busyCnt_q <= busyCnt_d;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  sequence csIdle;
    csN [*5];
  endsequence
  sequence cycleEnd;
    $fell(writeInProgress);
  endsequence
  busy_length_a: assert property (cycleEnd |-> (int'(busyCnt_q) >= WRITE_CYCLES - 1) &&
    (int'(busyCnt_q) <= WRITE_CYCLES + 1)) else $error("write cycle length wrong");
  busy_cap_a: assert property (int'(busyCnt_q) <= WRITE_CYCLES + 1)
    else $error("write cycle overran");
  cycle_clears_latch_a: assert property (cycleEnd |-> !writeEnableLatch)
    else $error("latch kept after write cycle");
  busy_holds_latch_a: assert property (writeInProgress |-> writeEnableLatch)
    else $error("write cycle without latch");
  busy_after_frame_a: assert property ($rose(writeInProgress) |-> csN && $past(csN))
    else $error("write cycle began inside a frame");
  latch_set_idle_a: assert property ($rose(writeEnableLatch) |-> csN && !writeInProgress)
    else $error("latch set mid frame or while busy");
  select_needs_latch_a: assert property (!$stable(protectSelect) |->
    $past(writeEnableLatch) && csN ##[0:4] writeInProgress)
    else $error("protect select changed without a write");
  oe_idle_a: assert property (csIdle |-> !soOe)
    else $error("output driven while deselected");
  oe_in_frame_a: assert property ($rose(soOe) |-> !csN && !$past(csN, 4))
    else $error("output enabled outside a frame");
  so_idle_a: assert property (!soOe |-> !so)
    else $error("reply line not low while undriven");
endmodule // spi_nvm_status_access_sva

// File: dv/spi_nvm_status_access_test.sv
// self-checking bench for the serial nonvolatile access block
`timescale 1ns/1ps
module spi_nvm_status_access_test;
  typedef logic [7:0] bq_t[$];
  localparam int WCYC = 600;
  localparam logic [7:0] SRR = nvm_pkg::OP_SR_READ;
  localparam logic [7:0] SRW = nvm_pkg::OP_SR_WRITE;
  localparam logic [7:0] WREN = nvm_pkg::OP_WR_EN;
  localparam logic [7:0] WRITE_DISABLE_CMD_ALIAS = nvm_pkg::OP_WR_DIS;
  localparam logic [7:0] ARR = nvm_pkg::OP_ARR_READ;
  localparam logic [7:0] ARW = nvm_pkg::OP_ARR_WRITE;
  localparam logic [7:0] PRR = nvm_pkg::OP_PROT_READ;
  localparam logic [7:0] PRW = nvm_pkg::OP_PROT_WRITE;
  localparam logic [7:0] UNL = nvm_pkg::OP_UNLOCK;
  logic clk = 1'h0;
  logic rst = 1'h1;
  logic csN, sck, si, so, soOe, writeInProgress, writeEnableLatch;
  logic [1:0] protectSelect;
  int n_fail = 0;
  int tests_run = 0;
  always #5 clk = ~clk;
  spi_host_model u_spi_host_model (.clk(clk), .so(so), .csN(csN), .sck(sck), .si(si));
  spi_nvm_status_access #(.WRITE_CYCLES(WCYC)) u_spi_nvm_status_access (.clk(clk),
    .rst(rst), .csN(csN), .sck(sck), .si(si), .so(so), .soOe(soOe),
    .writeInProgress(writeInProgress), .writeEnableLatch(writeEnableLatch),
    .protectSelect(protectSelect));
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic send(input bq_t tx, input int tail = 0);
    logic [7:0] rx;
    u_spi_host_model.select();
    foreach (tx[i]) u_spi_host_model.shift(tx[i], 8, rx);
    if (tail > 0) u_spi_host_model.shift(8'hFF, tail, rx);
    u_spi_host_model.deselect();
  endtask
  // a negative address means the command has no address byte
  task automatic rd_chk(input logic [7:0] op, input int adr, input bq_t exp, input logic oe);
    logic [7:0] rx;
    u_spi_host_model.select();
    u_spi_host_model.shift(op, 8, rx);
    if (adr >= 0) u_spi_host_model.shift(8'(adr), 8, rx);
    foreach (exp[i]) begin
      u_spi_host_model.shift(8'h00, 8, rx);
      if (oe) chk_byte(rx, exp[i]);
    end
    chk_byte({7'h00, soOe}, {7'h00, oe});
    u_spi_host_model.deselect();
  endtask
  task automatic poll(input logic [1:0] sel);
    logic [7:0] rx;
    rx = 8'h01;
    for (int k = 0; k < 40 && rx[0] !== 1'h0; k++) begin
      u_spi_host_model.select();
      u_spi_host_model.shift(SRR, 8, rx);
      u_spi_host_model.shift(8'h00, 8, rx);
      u_spi_host_model.deselect();
    end
    if (rx[0] !== 1'h0) begin
      n_fail++;
      $display("ERROR %0t write cycle never ended", $time);
      end_of_test();
    end
    chk_byte(rx, {4'h0, sel, 2'h0});
  endtask
  function automatic logic locked(input logic [1:0] sel, input logic [7:0] a);
    case (sel)
      2'h0: return 1'h0;
      2'h1: return a >= 8'hC0;
      2'h2: return a >= 8'h80;
      default: return 1'h1;
    endcase
  endfunction
  initial begin
    #900000;
    n_fail++;
    $display("ERROR %0t run too long", $time);
    end_of_test();
  end
  initial begin
    bq_t adrs;
    adrs = '{8'h40, 8'h88, 8'hC8};
    repeat (3) @(posedge clk);
    #1 rst = 1'h0;
    repeat (3) @(posedge clk);
    rd_chk(SRR, -1, '{8'h00, 8'h00}, 1'h1);
    send('{WREN});
    rd_chk(SRR, -1, '{8'h02}, 1'h1);
    send('{WRITE_DISABLE_CMD_ALIAS});
    rd_chk(SRR, -1, '{8'h00}, 1'h1);
    send('{WREN, ARW, 8'h10, 8'h77});
    rd_chk(SRR, -1, '{8'h00}, 1'h1);
    $display("test latch done");
    send('{WREN});
    send('{ARW, 8'h1E, 8'hA1, 8'hB2, 8'hC3});
    rd_chk(SRR, -1, '{8'h03}, 1'h1);
    rd_chk(ARR, 8'h1E, '{8'h00}, 1'h0);
    poll(2'h0);
    rd_chk(ARR, 8'h1E, '{8'hA1, 8'hB2}, 1'h1);
    rd_chk(ARR, 8'h18, '{8'hC3}, 1'h1);
    send('{WREN});
    send('{ARW, 8'h30, 8'h11}, 4);
    rd_chk(SRR, -1, '{8'h02}, 1'h1);
    send('{ARW, 8'hFF, 8'h5A});
    poll(2'h0);
    send('{WREN});
    send('{ARW, 8'h00, 8'hA5});
    poll(2'h0);
    rd_chk(ARR, 8'hFF, '{8'h5A, 8'hA5}, 1'h1);
    $display("test array done");
    send('{SRW, 8'h0C});
    chk_byte({6'h00, protectSelect}, 8'h00);
    for (int s = 3; s >= 0; s--) begin
      send('{WREN});
      send('{SRW, {4'hF, 2'(s), 2'h3}});
      poll(2'(s));
      foreach (adrs[j]) begin
        send('{WREN});
        send('{ARW, adrs[j], 8'h3C});
        chk_byte({7'h00, writeInProgress}, {7'h00, !locked(2'(s), adrs[j])});
        if (!locked(2'(s), adrs[j])) poll(2'(s));
        else send('{WRITE_DISABLE_CMD_ALIAS});
      end
    end
    $display("test protection done");
    send('{WREN});
    send('{UNL, 8'h55});
    send('{UNL, 8'hAA});
    send('{PRW, 8'h0E, 8'h61, 8'h62, 8'h63});
    poll(2'h0);
    rd_chk(PRR, 8'h0E, '{8'h61, 8'h62}, 1'h1);
    rd_chk(PRR, 8'h08, '{8'h63}, 1'h1);
    send('{WREN});
    send('{PRW, 8'h08, 8'h99});
    rd_chk(SRR, -1, '{8'h00}, 1'h1);
    rd_chk(PRR, 8'h08, '{8'h63}, 1'h1);
    send('{WREN});
    send('{UNL, 8'h55});
    send('{UNL, 8'h55});
    rd_chk(SRR, -1, '{8'h00}, 1'h1);
    send('{WREN});
    send('{UNL, 8'h55});
    send('{UNL, 8'hAA});
    send('{PRW, 8'h10, 8'h44});
    rd_chk(SRR, -1, '{8'h02}, 1'h1);
    send('{PRW, 8'h01, 8'h45});
    poll(2'h0);
    rd_chk(PRR, 8'h01, '{8'h45}, 1'h1);
    rd_chk(PRR, 8'h10, '{8'h00}, 1'h0);
    $display("test protected region done");
    end_of_test();
  end
endmodule // spi_nvm_status_access_test
bind spi_nvm_status_access spi_nvm_status_access_sva #(.WRITE_CYCLES(WRITE_CYCLES))
  u_spi_nvm_status_access_sva (.clk(clk), .rst(rst), .csN(csN), .so(so), .soOe(soOe),
  .writeInProgress(writeInProgress), .writeEnableLatch(writeEnableLatch),
  .protectSelect(protectSelect));
